//--- rtl/cet_pkg.sv
// constants and types shared by the command enable trigger block
package cet_pkg;
  // entries and transfer buffer layout
  localparam int CET_ENTRIES = 96;
  localparam int CET_COLS = 10;
  localparam int CET_CMD_WORDS = CET_ENTRIES * CET_COLS;
  localparam int CET_BUF_WORDS = 57;
  localparam int CET_EN_FIRST = 51;
  localparam int CET_EN_WORDS = 6;
  localparam int CET_CFG_FIRST = 1;
  localparam int CET_CFG_LAST = 50;
  // command list column positions
  localparam int CET_COL_PORT = 0;
  localparam int CET_COL_SLAVE = 1;
  localparam int CET_COL_FUNC = 2;
  localparam int CET_COL_SWAP = 6;
  localparam int CET_COL_POLL = 7;
  // port field, swap type and retry limit codes
  localparam logic [15:0] CET_PORT_ONE = 16'h0001;
  localparam logic [15:0] CET_PORT_TWO = 16'h0002;
  localparam logic [15:0] CET_PORT_CTL_ONE = 16'h0009;
  localparam logic [15:0] CET_PORT_CTL_TWO = 16'h000A;
  localparam logic [15:0] CET_SWAP_BYTES = 16'h0003;
  localparam logic [1:0] CET_MAX_TRIES = 2'h3;
  // register byte addresses
  localparam logic [15:0] CET_CTRL_ADDR = 16'h0000;
  localparam logic [15:0] CET_STATUS_ADDR = 16'h0004;
  localparam logic [15:0] CET_MASK_ADDR = 16'h0008;
  localparam logic [15:0] CET_STATE_ADDR = 16'h000C;
  localparam logic [15:0] CET_BUF_BASE = 16'h0100;
  localparam logic [15:0] CET_DONE_BASE = 16'h0200;
  localparam logic [15:0] CET_ERR_BASE = 16'h0220;
  localparam logic [15:0] CET_CMD_BASE = 16'h1000;
  // bit positions and reset values
  localparam int CET_CTRL_COMMIT_BIT = 0;
  localparam int CET_ST_DONE_BIT = 0;
  localparam int CET_ST_ERR_BIT = 1;
  localparam logic [1:0] CET_MASK_RESET = 2'h0;
  // one second of poll timer resolution
  localparam longint CET_SECOND_NS = 1000000000;
  localparam longint CET_CLK_NS = 4;
  localparam int CET_SECOND_CYCLES = int'(CET_SECOND_NS / CET_CLK_NS);

  typedef enum logic [2:0] {
    CET_IDLE = 3'b001,
    CET_START = 3'b010,
    CET_WAIT = 3'b100
  } cet_fsm_t;

  // request towards the serial send engine
  typedef struct packed {
    logic start;
    logic [6:0] entry;
    logic [1:0] port;
    logic [1:0] attempt;
    logic [15:0] slave;
    logic [15:0] func;
  } cet_send_t;

  // received data word towards the data tables
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } cet_rx_t;
endpackage

//--- rtl/cet_top.sv
// command enable trigger and retry logic with its ahb-lite register file
//
// Added by the designer: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - enable flags come from words 51 to 56 of each write transfer, sixteen per word.
// - word 51 bit 0 is entry one, entries ascend bit by bit and word by word.
// - enable words are taken on every write transfer whatever its block id.
// - words 1 to 50 are configuration and command list data, apart from the enables.
// - a command-control entry starts only on a 0 to 1 change of its enable flag.
// - a triggered command gets up to three send attempts before it fails.
// - a successful send sets the entry's done flag.
// - a failed send sets the entry's error flag.
// - port field 9 is command-control on port one, 10 on port two.
// - each command list entry is ten consecutive words, port field first.
// - each port field 1 or 2 entry's poll timer counts down once a second, fires at zero, then reloads.
// - swap type 3 exchanges the bytes of each received word, not the words.
module cet_top #(
  parameter int SECOND_CYCLES = cet_pkg::CET_SECOND_CYCLES
) (
  input wire logic clk_in, // 250 MHz clock
  input wire logic rst_in, // synchronous reset, high
  input wire logic hsel_in, // ahb slave select
  input wire logic [31:0] haddr_in, // ahb address
  input wire logic [1:0] htrans_in, // ahb transfer type
  input wire logic hwrite_in, // ahb write
  input wire logic [2:0] hsize_in, // ahb size, word only
  input wire logic [31:0] hwdata_in, // ahb write data
  input wire logic hready_in, // ahb bus ready
  output logic [31:0] hrdata_out, // ahb read data
  output logic hreadyout_out, // ahb slave ready
  output logic hresp_out, // ahb response, always okay
  output logic irq_out, // level interrupt
  output cet_pkg::cet_send_t send_out, // send request
  input wire logic send_ok_in, // attempt succeeded, pulse
  input wire logic send_fail_in, // attempt failed, pulse
  input wire cet_pkg::cet_rx_t rx_in, // received word from link
  output cet_pkg::cet_rx_t rx_out // received word after swap
);
  import cet_pkg::*;

  typedef struct packed {
    logic hready;
    logic [31:0] rdata;
    logic dp_wr;
    logic [15:0] dp_addr;
    logic [CET_ENTRIES-1:0] pend;
    logic [CET_ENTRIES-1:0] en_old;
    logic [CET_ENTRIES-1:0] done;
    logic [CET_ENTRIES-1:0] err;
    logic [1:0] status;
    logic [1:0] mask;
    logic irq;
    cet_fsm_t fsm;
    logic [6:0] cur;
    logic [1:0] tries;
    cet_send_t send;
    cet_rx_t rx;
    logic [31:0] tick_cnt;
    logic sweep;
    logic [6:0] ptr;
  } cet_state_t;

  cet_state_t s_reg;
  cet_state_t s_next;
  logic [15:0] buf_mem [CET_BUF_WORDS];
  logic [15:0] cmd_mem [CET_CMD_WORDS];
  logic [15:0] port_mem [CET_ENTRIES];
  logic [15:0] timer_mem [CET_ENTRIES];
  logic buf_we;
  logic [5:0] buf_idx;
  logic cmd_we;
  logic [9:0] cmd_idx;
  logic port_we;
  logic [6:0] port_idx;
  logic timer_we;
  logic [15:0] timer_val;
  logic [15:0] wdata16;
  logic [CET_ENTRIES-1:0] en_now;
  logic [CET_ENTRIES-1:0] trig;
  logic [6:0] pick;
  logic found;
  logic [15:0] cur_port;
  logic [15:0] cur_swap;
  logic [15:0] ptr_port;
  logic [15:0] ptr_preset;

  // lowest numbered pending entry goes first
  function automatic logic [7:0] first_set(input logic [CET_ENTRIES-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = CET_ENTRIES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 7'(i)};
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // enable flags gathered from the transfer buffer
  always_comb begin
    for (int w = 0; w < CET_EN_WORDS; w++) begin
      en_now[w*16 +: 16] = buf_mem[CET_EN_FIRST + w];
    end
  end

  // command-control entries fire on a rising flag only
  always_comb begin
    for (int i = 0; i < CET_ENTRIES; i++) begin
      trig[i] = en_now[i] && !s_reg.en_old[i]
        && (port_mem[i] == CET_PORT_CTL_ONE || port_mem[i] == CET_PORT_CTL_TWO);
    end
  end

  // table lookups for the current send and the sweep pointer
  assign {found, pick} = first_set(s_reg.pend);
  assign cur_port = port_mem[s_reg.cur];
  assign cur_swap = cmd_mem[10'(s_reg.cur * CET_COLS + CET_COL_SWAP)];
  assign ptr_port = port_mem[s_reg.ptr];
  assign ptr_preset = cmd_mem[10'(s_reg.ptr * CET_COLS + CET_COL_POLL)];
  assign wdata16 = hwdata_in[15:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [15:0] a;
    logic [15:0] ra;
    logic commit;
    logic [1:0] clr;
    logic [1:0] ev;
    logic [CET_ENTRIES-1:0] take;
    logic [CET_ENTRIES-1:0] add;
    logic [CET_ENTRIES-1:0] set_done;
    logic [CET_ENTRIES-1:0] set_err;
    a = s_reg.dp_addr;
    ra = haddr_in[15:0];
    commit = 1'b0;
    clr = 2'h0;
    ev = 2'h0;
    take = '0;
    add = '0;
    set_done = '0;
    set_err = '0;
    s_next = s_reg;
    buf_we = 1'b0;
    buf_idx = 6'h00;
    cmd_we = 1'b0;
    cmd_idx = 10'h000;
    port_we = 1'b0;
    port_idx = 7'h00;
    timer_we = 1'b0;
    timer_val = 16'h0000;
    s_next.send.start = 1'b0;
    s_next.rx.valid = 1'b0;

    // bus data phase: writes land one cycle after their address
    s_next.dp_wr = 1'b0;
    if (s_reg.dp_wr) begin
      if (a == CET_CTRL_ADDR) begin
        commit = hwdata_in[CET_CTRL_COMMIT_BIT];
      end else if (a == CET_STATUS_ADDR) begin
        clr = hwdata_in[1:0];
      end else if (a == CET_MASK_ADDR) begin
        s_next.mask = hwdata_in[1:0];
      end else if (a >= CET_BUF_BASE && a < CET_BUF_BASE + 16'(CET_BUF_WORDS * 4)) begin
        buf_we = 1'b1;
        buf_idx = 6'((a - CET_BUF_BASE) >> 2);
      end else if (a >= CET_CMD_BASE && a < CET_CMD_BASE + 16'(CET_CMD_WORDS * 4)) begin
        cmd_we = 1'b1;
        cmd_idx = 10'((a - CET_CMD_BASE) >> 2);
        port_idx = 7'(cmd_idx / 10'(CET_COLS));
        port_we = (cmd_idx % 10'(CET_COLS)) == 10'(CET_COL_PORT);
      end
    end

    // bus address phase: read data is fetched now, shown in the data phase
    if (hsel_in && htrans_in[1] && hready_in) begin
      s_next.dp_wr = hwrite_in;
      s_next.dp_addr = ra;
      s_next.rdata = 32'h0000_0000;
      if (!hwrite_in) begin
        if (ra == CET_STATUS_ADDR) begin
          s_next.rdata = {30'h0, s_reg.status};
        end else if (ra == CET_MASK_ADDR) begin
          s_next.rdata = {30'h0, s_reg.mask};
        end else if (ra == CET_STATE_ADDR) begin
          s_next.rdata = {16'h0, s_reg.send.attempt, s_reg.cur, 4'h0, s_reg.fsm};
        end else if (ra >= CET_BUF_BASE && ra < CET_BUF_BASE + 16'(CET_BUF_WORDS * 4)) begin
          s_next.rdata = {16'h0, buf_mem[6'((ra - CET_BUF_BASE) >> 2)]};
        end else if (ra >= CET_DONE_BASE && ra < CET_DONE_BASE + 16'(CET_EN_WORDS * 4)) begin
          s_next.rdata = {16'h0, s_reg.done[((ra - CET_DONE_BASE) >> 2) * 16 +: 16]};
        end else if (ra >= CET_ERR_BASE && ra < CET_ERR_BASE + 16'(CET_EN_WORDS * 4)) begin
          s_next.rdata = {16'h0, s_reg.err[((ra - CET_ERR_BASE) >> 2) * 16 +: 16]};
        end else if (ra >= CET_CMD_BASE && ra < CET_CMD_BASE + 16'(CET_CMD_WORDS * 4)) begin
          s_next.rdata = {16'h0, cmd_mem[10'((ra - CET_CMD_BASE) >> 2)]};
        end
      end
    end

    // a committed transfer samples all enable words, whatever its id word holds
    if (commit) begin
      add = add | trig;
      s_next.en_old = en_now;
    end

    // one second divider starts a sweep over every poll timer
    if (s_reg.tick_cnt >= 32'(SECOND_CYCLES - 1)) begin
      s_next.tick_cnt = 32'h0;
      s_next.sweep = 1'b1;
      s_next.ptr = 7'h00;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 32'h1;
    end

    // one entry per cycle; only plain port modes are timer driven
    if (s_reg.sweep) begin
      if (ptr_port == CET_PORT_ONE || ptr_port == CET_PORT_TWO) begin
        timer_we = 1'b1;
        if (timer_mem[s_reg.ptr] == 16'h0000) begin
          add[s_reg.ptr] = 1'b1;
          timer_val = ptr_preset;
        end else begin
          timer_val = timer_mem[s_reg.ptr] - 16'h0001;
        end
      end
      if (s_reg.ptr == 7'(CET_ENTRIES - 1)) begin
        s_next.sweep = 1'b0;
      end else begin
        s_next.ptr = s_reg.ptr + 7'h01;
      end
    end

    // send sequencer with retries
    case (s_reg.fsm)
      CET_IDLE: begin
        if (found) begin
          take[pick] = 1'b1;
          s_next.cur = pick;
          s_next.tries = 2'h1;
          s_next.fsm = CET_START;
        end
      end
      CET_START: begin
        s_next.send.start = 1'b1;
        s_next.send.entry = s_reg.cur;
        // attempt counted apart so send fields only move together with start
        s_next.send.attempt = s_reg.tries;
        s_next.send.port = (cur_port == CET_PORT_CTL_TWO || cur_port == CET_PORT_TWO) ? 2'h2 : 2'h1;
        s_next.send.slave = cmd_mem[10'(s_reg.cur * CET_COLS + CET_COL_SLAVE)];
        s_next.send.func = cmd_mem[10'(s_reg.cur * CET_COLS + CET_COL_FUNC)];
        s_next.fsm = CET_WAIT;
      end
      CET_WAIT: begin
        if (send_ok_in) begin
          set_done[s_reg.cur] = 1'b1;
          ev[CET_ST_DONE_BIT] = 1'b1;
          s_next.fsm = CET_IDLE;
        end else if (send_fail_in) begin
          if (s_reg.tries == CET_MAX_TRIES) begin
            set_err[s_reg.cur] = 1'b1;
            ev[CET_ST_ERR_BIT] = 1'b1;
            s_next.fsm = CET_IDLE;
          end else begin
            s_next.tries = s_reg.tries + 2'h1;
            s_next.fsm = CET_START;
          end
        end
      end
      default: begin
        s_next.fsm = CET_IDLE;
      end
    endcase

    // a fresh command-control trigger clears old results; new events beat any clear
    s_next.pend = (s_reg.pend & ~take) | add;
    s_next.done = (s_reg.done & ~(commit ? trig : '0)) | set_done;
    s_next.err = (s_reg.err & ~(commit ? trig : '0)) | set_err;
    s_next.status = (s_reg.status & ~clr) | ev;
    s_next.irq = |(s_next.status & s_next.mask);

    // byte swap within each word for swap type 3, words stay in order
    if (rx_in.valid) begin
      s_next.rx.valid = 1'b1;
      s_next.rx.data = (cur_swap == CET_SWAP_BYTES) ? {rx_in.data[7:0], rx_in.data[15:8]}
        : rx_in.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
      s_reg.hready <= 1'b1;
      s_reg.fsm <= CET_IDLE;
      s_reg.mask <= CET_MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // tables; the command list holds data only and needs no reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < CET_BUF_WORDS; i++) begin
        buf_mem[i] <= 16'h0000;
      end
      for (int i = 0; i < CET_ENTRIES; i++) begin
        port_mem[i] <= 16'h0000;
        timer_mem[i] <= 16'h0000;
      end
    end else begin
      if (buf_we) begin
        buf_mem[buf_idx] <= wdata16;
      end
      if (port_we) begin
        port_mem[port_idx] <= wdata16;
      end
      if (timer_we) begin
        timer_mem[s_reg.ptr] <= timer_val;
      end
    end
  end

  // command list words, ten per entry
  always_ff @(posedge clk_in) begin
    if (cmd_we) begin
      cmd_mem[cmd_idx] <= wdata16;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops, hresp tied to okay
  assign hrdata_out = s_reg.rdata;
  assign hreadyout_out = s_reg.hready;
  assign hresp_out = 1'b0;
  assign irq_out = s_reg.irq;
  assign send_out = s_reg.send;
  assign rx_out = s_reg.rx;
endmodule

//--- bench/cet_props.sv
// port assertions for the command enable trigger block
`timescale 1ns/1ps
module cet_props
  import cet_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_in, // synchronous reset
  input wire logic hreadyout_out, // slave ready
  input wire logic hresp_out, // slave response
  input wire cet_send_t send_out, // send request
  input wire logic send_ok_in, // attempt succeeded
  input wire logic send_fail_in, // attempt failed
  input wire cet_rx_t rx_in, // raw received word
  input wire cet_rx_t rx_out // word after swap
);
  logic wait_reg;
  logic wait_next;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // an attempt is in flight; results outside it are ignored by the block
  always_comb begin
    wait_next = wait_reg;
    if (send_out.start) wait_next = 1'b1;
    else if (send_ok_in || send_fail_in) wait_next = 1'b0;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) wait_reg <= 1'b0;
    else wait_reg <= wait_next;
  end
  ////////////////////////////////////////////////////////////
  sequence s_early_fail;
    wait_reg && send_fail_in && !send_ok_in && send_out.attempt != 2'h3;
  endsequence
  sequence s_restart;
    send_out.start && send_out.attempt == $past(send_out.attempt, 2) + 2'h1
      && send_out.entry == $past(send_out.entry, 2);
  endsequence
  sequence s_last_fail;
    wait_reg && send_fail_in && !send_ok_in && send_out.attempt == 2'h3;
  endsequence
  property p_retry; s_early_fail |-> ##2 s_restart; endproperty
  property p_give_up; s_last_fail |=> !send_out.start [*2]; endproperty
  property p_ok_stop; wait_reg && send_ok_in |=> !send_out.start [*2]; endproperty
  property p_pulse; send_out.start |=> !send_out.start; endproperty
  property p_port;
    send_out.start |-> (send_out.port == 2'h1 || send_out.port == 2'h2);
  endproperty
  property p_attempt; send_out.start |-> send_out.attempt != 2'h0; endproperty
  property p_hold;
    !send_out.start |-> $stable({send_out.entry, send_out.port, send_out.attempt});
  endproperty
  property p_rx;
    ##1 rx_out.valid == $past(rx_in.valid) && (!rx_out.valid || rx_out.data == $past(rx_in.data)
      || rx_out.data == {$past(rx_in.data[7:0]), $past(rx_in.data[15:8])});
  endproperty
  property p_bus; hreadyout_out && !hresp_out; endproperty
  a_retry: assert property (p_retry) else $error("retry not restarted");
  a_give_up: assert property (p_give_up) else $error("fourth attempt");
  a_ok_stop: assert property (p_ok_stop) else $error("resent after ok");
  a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
  a_port: assert property (p_port) else $error("bad send port");
  a_attempt: assert property (p_attempt) else $error("attempt zero");
  a_hold: assert property (p_hold) else $error("send fields moved");
  a_rx: assert property (p_rx) else $error("rx word wrong");
  a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule
bind cet_top cet_props u_cet_props (.clk_in(clk_in), .rst_in(rst_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .send_out(send_out),
  .send_ok_in(send_ok_in), .send_fail_in(send_fail_in), .rx_in(rx_in), .rx_out(rx_out));

//--- bench/cet_send_model.sv
// behavioural serial send engine answering each attempt
`timescale 1ns/1ps
module cet_send_model
  import cet_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_in, // reset
  input wire cet_send_t send_in, // request from the block
  input wire logic [1:0] fails_in, // attempts refused before success
  input wire logic [3:0] delay_in, // answer latency, at least 1
  output logic ok_out, // attempt succeeded pulse
  output logic fail_out // attempt failed pulse
);
  int cnt;
  logic [1:0] att;
  // one pulse per attempt, late answers model a slow slave
  always @(posedge clk_in) begin
    ok_out <= 1'b0;
    fail_out <= 1'b0;
    if (rst_in) cnt <= 0;
    else if (send_in.start) begin
      cnt <= int'(delay_in);
      att <= send_in.attempt;
    end else if (cnt == 1) begin
      cnt <= 0;
      if (att <= fails_in) fail_out <= 1'b1;
      else ok_out <= 1'b1;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule

//--- bench/command_enable_trigger_control_tb_top.sv
// self-checking bench for the command enable trigger block
`timescale 1ns/1ps
module command_enable_trigger_control_tb_top
  import cet_pkg::*;
;
  logic clk_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, fails = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] delay = 4'h1;
  logic hreadyout, hresp, irq, send_ok, send_fail;
  cet_send_t send;
  cet_rx_t rxi = '0, rxo;
  int num_errors = 0, compares = 0;
  always #2 clk_in = ~clk_in;
  cet_top #(.SECOND_CYCLES(200)) u_cet_top (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .irq_out(irq), .send_out(send), .send_ok_in(send_ok),
    .send_fail_in(send_fail), .rx_in(rxi), .rx_out(rxo));
  cet_send_model u_cet_send_model (.clk_in(clk_in), .rst_in(rst_in), .send_in(send),
    .fails_in(fails), .delay_in(delay), .ok_out(send_ok), .fail_out(send_fail));
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic bus_edge();
    int n;
    n = 0;
    @(posedge clk_in);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        num_errors++;
        tally_and_finish();
      end else @(posedge clk_in);
    end
  endtask
  // one single word transfer, then an idle cycle
  task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {16'h0000, a};
    hwrite <= wr;
    bus_edge();
    htrans <= 2'h0;
    hwdata <= wd;
    bus_edge();
    rd = hrdata;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x, exp, what);
  endtask
  task automatic cmd_set(input int e, input logic [15:0] port, input logic [15:0] swap,
                         input logic [15:0] poll);
    wr(CET_CMD_BASE + 16'(4 * (e * 10 + 1)), {16'h0, 16'(32'h30 + e)});
    wr(CET_CMD_BASE + 16'(4 * (e * 10 + 2)), {16'h0, 16'(32'h20 + e)});
    wr(CET_CMD_BASE + 16'(4 * (e * 10 + 6)), {16'h0, swap});
    wr(CET_CMD_BASE + 16'(4 * (e * 10 + 7)), {16'h0, poll});
    wr(CET_CMD_BASE + 16'(4 * e * 10), {16'h0, port});
  endtask
  task automatic enable(input int k, input logic [15:0] v);
    wr(CET_BUF_BASE + 16'(4 * (CET_EN_FIRST + k)), {16'h0, v});
    wr(CET_CTRL_ADDR, 32'h1);
  endtask
  task automatic expect_start(input int bound, input int e, input logic [1:0] p,
                              input logic [1:0] a);
    int n;
    n = 0;
    @(posedge clk_in);
    while (send.start !== 1'b1) begin
      n++;
      if (n > bound) begin
        num_errors++;
        tally_and_finish();
      end else @(posedge clk_in);
    end
    check({5'h0, send.entry, send.port, send.attempt, send.slave},
          {5'h0, 7'(e), p, a, 16'(32'h30 + e)}, "send fields");
    check({16'h0, send.func}, {16'h0, 16'(32'h20 + e)}, "send func");
  endtask
  task automatic no_start(input int cycles);
    logic seen;
    seen = 1'b0;
    repeat (cycles) begin
      @(posedge clk_in);
      if (send.start !== 1'b0) seen = 1'b1;
    end
    check({31'h0, seen}, 32'h0, "unexpected start");
  endtask
  task automatic rx_chk(input logic [15:0] d, input logic [15:0] exp);
    rxi <= '{valid: 1'b1, data: d};
    @(posedge clk_in);
    rxi <= '0;
    @(posedge clk_in);
    check({15'h0, rxo}, {15'h0, 1'b1, exp}, "rx word");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    check({29'h0, irq, send.start, hresp}, 32'h0, "reset outputs");
    rd_chk(CET_STATUS_ADDR, 32'h0, "status reset");
    rd_chk(CET_MASK_ADDR, 32'h0, "mask reset");
    rd_chk(CET_STATE_ADDR, 32'h1, "state reset");
    rd_chk(16'h0010, 32'h0, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_one();
    cmd_set(0, CET_PORT_CTL_ONE, 16'h0, 16'h0);
    wr(CET_BUF_BASE, 32'h00FF);
    for (int w = CET_CFG_FIRST; w <= CET_CFG_LAST; w++) wr(CET_BUF_BASE + 16'(4 * w), 32'hFFFF);
    wr(CET_CTRL_ADDR, 32'h1);
    no_start(20);
    enable(0, 16'h0001);
    expect_start(20, 0, 2'h1, 2'h1);
    repeat (6) @(posedge clk_in);
    rd_chk(CET_DONE_BASE, 32'h1, "done entry one");
    rd_chk(CET_ERR_BASE, 32'h0, "no error entry one");
    rd_chk(CET_STATUS_ADDR, 32'h1, "done event");
    $display("test single trigger done");
  endtask
  task automatic t_hold();
    wr(CET_CTRL_ADDR, 32'h1);
    no_start(30);
    rd_chk(CET_DONE_BASE, 32'h1, "done kept");
    enable(0, 16'h0000);
    no_start(10);
    enable(0, 16'h0001);
    expect_start(20, 0, 2'h1, 2'h1);
    // let the answer land before the next test clears status
    repeat (6) @(posedge clk_in);
    rd_chk(CET_DONE_BASE, 32'h1, "done again");
    $display("test held enable done");
  endtask
  task automatic t_fail();
    wr(CET_STATUS_ADDR, 32'h3);
    wr(CET_MASK_ADDR, 32'h2);
    cmd_set(16, CET_PORT_CTL_TWO, CET_SWAP_BYTES, 16'h0);
    fails <= 2'h3;
    enable(1, 16'h0001);
    for (int i = 1; i <= 3; i++) expect_start(20, 16, 2'h2, 2'(i));
    no_start(10);
    rd_chk(CET_ERR_BASE + 16'h4, 32'h1, "error entry 17");
    rd_chk(CET_DONE_BASE + 16'h4, 32'h0, "no done entry 17");
    rd_chk(CET_STATUS_ADDR, 32'h2, "error event");
    check({31'h0, irq}, 32'h1, "irq raised");
    wr(CET_STATUS_ADDR, 32'h2);
    check({31'h0, irq}, 32'h0, "irq cleared");
    rx_chk(16'h12AB, 16'hAB12);
    $display("test three failures done");
  endtask
  task automatic t_retry_ok();
    cmd_set(95, CET_PORT_CTL_ONE, 16'h0, 16'h0);
    fails <= 2'h2;
    delay <= 4'h9;
    enable(5, 16'h8000);
    for (int i = 1; i <= 3; i++) expect_start(30, 95, 2'h1, 2'(i));
    repeat (14) @(posedge clk_in);
    rd_chk(CET_DONE_BASE + 16'h14, 32'h8000, "done entry 96");
    rd_chk(CET_ERR_BASE + 16'h14, 32'h0, "no error entry 96");
    rx_chk(16'h12AB, 16'h12AB);
    $display("test slow retry done");
  endtask
  task automatic t_poll();
    fails <= 2'h0;
    delay <= 4'h1;
    cmd_set(5, CET_PORT_ONE, 16'h0, 16'h1);
    expect_start(500, 5, 2'h1, 2'h1);
    no_start(350);
    expect_start(500, 5, 2'h1, 2'h1);
    $display("test poll timer done");
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_one();
    t_hold();
    t_fail();
    t_retry_ok();
    t_poll();
    tally_and_finish();
  end
endmodule
